/* core/fpet_sequencer.sv */
// Flash program/erase timing sequencer, clocked by the timing generator.
// Assumes clk is the generator clock kept in band by software.
// Phase lengths are hardwired; only the block size is a parameter.
//
// Function
// - Word program lasts 35 periods
// - First block item takes 30 periods
// - Further block items take 21, 64 max
// - Block end sequence waits 6 periods
// - Segment erase 4819, mass erase 5297
//
// A start in idle loads the timer and raises the enable on one edge.
// Block mode waits between items; blockLast or a full block ends it.
// There is no time-out in the wait: software must end any block short of full.
module fpet_sequencer
    import fpet_pkg::*;
#(
    parameter int BLOCK_ITEMS = `FPET_BLOCK_ITEMS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Operation request
    input wire logic start,
    input wire fpet_op_t op,
    // Block mode item flow
    input wire logic itemValid,
    input wire logic blockLast,
    // Flash array controls
    output logic progEn,
    output logic eraseEn,
    output logic massEn,
    // Status
    output logic busy,
    output logic done,
    output logic itemTaken
);
    // Timer width covers the longest erase phase
    localparam int TW = 13;
    // Index width covers one block
    localparam int IW = $clog2(BLOCK_ITEMS);

    // Sequencer state and its phase timer
    fpet_state_t state_r; // Sequencer state
    fpet_op_t op_r; // Operation held for the sequence
    logic load; // Timer load strobe
    logic [TW-1:0] loadValue; // Phase length
    logic tDone; // Timer on last period
    // Block bookkeeping
    logic [IW-1:0] item_r; // Item index in block
    logic done_r; // Completion pulse
    // Registered array controls, so the array never sees a glitch
    logic progEn_r; // Program phase
    logic eraseEn_r; // Erase phase
    logic massEn_r; // Erase kind
    logic blockFull; // Index at last position

    // Refuse block sizes the index and the item rules cannot serve
    if (BLOCK_ITEMS < 2 || BLOCK_ITEMS > `FPET_BLOCK_ITEMS) begin
        $error("BLOCK_ITEMS out of range");
    end

    // Phase length from the operation
    // Taken at start only; later block phases are loaded from the wait state
    function automatic logic [TW-1:0] opLen(input fpet_op_t o);
        unique case (o)
            FPET_OP_WORD: opLen = TW'(`FPET_WORD_PERIODS);
            FPET_OP_BLOCK: opLen = TW'(`FPET_BLOCK_FIRST_PERIODS);
            FPET_OP_SEG_ERASE: opLen = TW'(`FPET_SEG_ERASE_PERIODS);
            FPET_OP_MASS_ERASE: opLen = TW'(`FPET_MASS_ERASE_PERIODS);
            // Codes outside the enum fall back to the word length
            default: opLen = TW'(`FPET_WORD_PERIODS);
        endcase
    endfunction

    // Last position reached: the next wait ends the block
    assign blockFull = (item_r == IW'(BLOCK_ITEMS - 1));

    // Timer loads on start, on each next item, and on block end
    always_comb begin
        load = 1'b0;
        loadValue = '0;
        itemTaken = 1'b0;
        unique case (state_r)
            FPET_IDLE: begin
                // Idle: a start loads the phase of its operation
                if (start) begin
                    load = 1'b1;
                    loadValue = opLen(op);
                end
            end
            FPET_BLK_WAIT: begin
                // Block end wins over a pending item
                if (blockLast || blockFull) begin
                    load = 1'b1;
                    loadValue = TW'(`FPET_BLOCK_END_PERIODS);
                end else if (itemValid) begin
                    load = 1'b1;
                    itemTaken = 1'b1;
                    loadValue = TW'(`FPET_BLOCK_NEXT_PERIODS);
                end
            end
            default: begin
                // Other states let the timer run down
            end
        endcase
    end

    // One shared down counter times every phase
    fpet_period_timer #(.WIDTH(TW)) fpet_period_timer_inst (
        .clk(clk),
        .rst(rst),
        .load(load),
        .loadValue(loadValue),
        .done(tDone)
    );

    // State sequence; new requests only taken in idle
    // Requests outside idle are dropped with no indication
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= FPET_IDLE;
        end else begin
            unique case (state_r)
                FPET_IDLE: begin
                    if (start) begin
                        unique case (op)
                            FPET_OP_WORD: state_r <= FPET_PROG;
                            FPET_OP_BLOCK: state_r <= FPET_PROG;
                            default: state_r <= FPET_ERASE;
                        endcase
                    end
                end
                FPET_PROG: begin
                    // Word ends here; a block item returns to wait
                    if (tDone && op_r == FPET_OP_BLOCK)
                        state_r <= FPET_BLK_WAIT;
                    else if (tDone)
                        state_r <= FPET_IDLE;
                end
                FPET_BLK_WAIT: begin
                    // Stay here until an item arrives or the block ends
                    if (blockLast || blockFull)
                        state_r <= FPET_BLK_END;
                    else if (itemValid)
                        state_r <= FPET_PROG;
                end
                FPET_BLK_END: begin
                    // End wait runs out, then the block is done
                    if (tDone) state_r <= FPET_IDLE;
                end
                FPET_ERASE: begin
                    // Segment or mass erase, one timed run
                    if (tDone) state_r <= FPET_IDLE;
                end
            endcase
        end
    end

    // Latch operation at start
    // Held so a change of op cannot alter a running sequence
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_r <= FPET_OP_WORD;
        end else if (state_r == FPET_IDLE && start) begin
            op_r <= op;
        end
    end

    // Item index within the block
    // Cleared in idle so each block starts at position zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            item_r <= '0;
        end else if (state_r == FPET_IDLE) begin
            item_r <= '0;
        end else if (itemTaken) begin
            item_r <= item_r + IW'(1);
        end
    end

    // Array enables follow the phase
    // Enables rise on the start edge, so each phase count is exact
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            progEn_r <= 1'b0;
            eraseEn_r <= 1'b0;
            massEn_r <= 1'b0;
        end else begin
            progEn_r <= (state_r == FPET_IDLE && start
                && (op == FPET_OP_WORD || op == FPET_OP_BLOCK))
                || (state_r == FPET_PROG && !tDone)
                || (state_r == FPET_BLK_WAIT && itemTaken);
            eraseEn_r <= (state_r == FPET_IDLE && start
                && (op == FPET_OP_SEG_ERASE || op == FPET_OP_MASS_ERASE))
                || (state_r == FPET_ERASE && !tDone);
            // Erase kind holds after the run until the next start
            if (state_r == FPET_IDLE && start)
                massEn_r <= (op == FPET_OP_MASS_ERASE);
        end
    end

    // One pulse when a sequence ends
    // Item ends inside a block give no pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= tDone && (state_r == FPET_ERASE
                || state_r == FPET_BLK_END
                || (state_r == FPET_PROG && op_r == FPET_OP_WORD));
        end
    end

    // Busy is combinational, so a start in the done cycle is taken
    assign busy = (state_r != FPET_IDLE);
    // Remaining outputs except itemTaken come straight from flip-flops
    assign done = done_r;
    assign progEn = progEn_r;
    assign eraseEn = eraseEn_r;
    assign massEn = massEn_r;
endmodule // fpet_sequencer

/* shared/fpet_consts.svh */
// Timing constants of the flash program/erase timer.
// Assumes inclusion by the package and the design files by bare name.
`ifndef FPET_CONSTS_SVH
`define FPET_CONSTS_SVH
// Phase lengths in timing generator periods
`define FPET_WORD_PERIODS 35
`define FPET_BLOCK_FIRST_PERIODS 30
`define FPET_BLOCK_NEXT_PERIODS 21
`define FPET_BLOCK_END_PERIODS 6
`define FPET_SEG_ERASE_PERIODS 4819
`define FPET_MASS_ERASE_PERIODS 5297
// Largest block size in items
`define FPET_BLOCK_ITEMS 64
// Frequency band of the timing generator, kHz
`define FPET_FREQ_MIN_KHZ 257
`define FPET_FREQ_MAX_KHZ 476
`endif

/* shared/fpet_pkg.sv */
// Types shared by the flash program/erase timer.
// Assumes the constants header is on the include path.
package fpet_pkg;
    `include "fpet_consts.svh"
    // Operation requested by software
    typedef enum logic [2:0] {
        FPET_OP_WORD,
        FPET_OP_BLOCK,
        FPET_OP_SEG_ERASE,
        FPET_OP_MASS_ERASE
    } fpet_op_t;
    // Sequencer states
    typedef enum logic [2:0] {
        FPET_IDLE,
        FPET_PROG,
        FPET_BLK_WAIT,
        FPET_BLK_END,
        FPET_ERASE
    } fpet_state_t;
endpackage

/* core/fpet_period_timer.sv */
// Down counter that times one phase in generator periods.
// Assumes load and loadValue come from the sequencer in the same clock.
module fpet_period_timer
    import fpet_pkg::*;
#(
    parameter int WIDTH = 13
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    // Status
    output logic done
);
    logic [WIDTH-1:0] count_r; // Periods still to run

    // Refuse widths too narrow for the longest erase
    if (WIDTH < 13) begin
        $error("WIDTH too small for erase lengths");
    end

    // Load a phase or count it down to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= '0;
        end else if (load) begin
            count_r <= loadValue;
        end else if (count_r != '0) begin
            count_r <= count_r - WIDTH'(1);
        end
    end

    // Last period of the phase
    assign done = (count_r == WIDTH'(1));
endmodule // fpet_period_timer

/* verification/fpet_seq_properties.sv */
// Port-level assertions of the program/erase sequencer.
// Assumes binding onto fpet_sequencer; run counters are helper logic.
module fpet_seq_checker
    import fpet_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Requests
    input wire logic start,
    input wire fpet_op_t op,
    input wire logic blockLast,
    // Watched outputs
    input wire logic progEn,
    input wire logic eraseEn,
    input wire logic massEn,
    input wire logic busy,
    input wire logic done
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [12:0] progLen_r; // Cycles of current program run
    logic [12:0] eraseLen_r; // Cycles of current erase run
    logic blkMode_r; // Block operation in flight
    logic take; // Accepted start
    assign take = start && !busy;
    // Run lengths, cleared between runs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            progLen_r <= '0;
            eraseLen_r <= '0;
        end else begin
            progLen_r <= progEn ? progLen_r + 13'h1 : 13'h0;
            eraseLen_r <= eraseEn ? eraseLen_r + 13'h1 : 13'h0;
        end
    end
    // Mode kept from the accepted start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) blkMode_r <= 1'b0;
        else if (take) blkMode_r <= (op == FPET_OP_BLOCK);
    end
    sequence s_word;
        ##1 progEn ##34 progEn ##1 (!progEn && done);
    endsequence
    sequence s_endWait;
        !done[*6] ##[1:2] done;
    endsequence
    AST_WORD: assert property (
        take && op == FPET_OP_WORD |-> s_word) else $error("word run");
    AST_BLK_FIRST: assert property (
        take && op == FPET_OP_BLOCK |-> ##30 progEn ##1 !progEn)
        else $error("first item run");
    AST_RUN_LEN: assert property (
        $fell(progEn) |-> progLen_r inside {13'h23, 13'h1E, 13'h15})
        else $error("program run length");
    AST_BLK_END: assert property (
        blkMode_r && $fell(progEn) && blockLast |-> s_endWait)
        else $error("block end wait");
    AST_SEG: assert property (
        $fell(eraseEn) && !$past(massEn) |-> eraseLen_r == 13'h12D3)
        else $error("segment erase length");
    AST_MASS: assert property (
        $fell(eraseEn) && $past(massEn) |-> eraseLen_r == 13'h14B1)
        else $error("mass erase length");
    AST_BUSY: assert property (
        progEn || eraseEn |-> busy) else $error("busy dropped");
    AST_TAKE: assert property (
        take |=> busy && !done) else $error("start not taken");
endmodule // fpet_seq_checker
bind fpet_sequencer fpet_seq_checker fpet_seq_checker_inst (.clk, .rst,
    .start, .op, .blockLast, .progEn, .eraseEn, .massEn, .busy, .done);

/* verification/fpet_flash_model.sv */
// Flash array stand-in: counts the program and erase phases it sees.
// Assumes the sequencer's array controls are wired straight in.
module fpet_flash_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Array controls
    input wire logic progEn,
    input wire logic eraseEn,
    input wire logic massEn,
    // Counts for the bench
    output logic [15:0] progPulses,
    output logic [15:0] erasePulses,
    output logic [15:0] massPulses
);
    logic progD_r; // Last program enable
    logic eraseD_r; // Last erase enable
    // A rising enable is one item written or one erase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {progD_r, eraseD_r} <= 2'h0;
            {progPulses, erasePulses, massPulses} <= '0;
        end else begin
            progD_r <= progEn;
            eraseD_r <= eraseEn;
            if (progEn && !progD_r) progPulses <= progPulses + 16'h1;
            if (eraseEn && !eraseD_r) erasePulses <= erasePulses + 16'h1;
            if (eraseEn && !eraseD_r && massEn)
                massPulses <= massPulses + 16'h1;
        end
    end
endmodule // fpet_flash_model

/* verification/fpet_sequencer_tb_top.sv */
// Self-checking bench of the program/erase sequencer.
// Assumes package, checker and array model are compiled first.
module fpet_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fpet_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    fpet_op_t op = FPET_OP_WORD;
    logic itemValid = 1'b0;
    logic blockLast = 1'b0;
    logic progEn, eraseEn, massEn, busy, done, itemTaken;
    logic [15:0] progPulses, erasePulses, massPulses;
    int fails = 0;
    int cmp_count = 0;
    int n;
    fpet_sequencer fpet_sequencer_inst (.clk, .rst, .start, .op, .itemValid,
        .blockLast, .progEn, .eraseEn, .massEn, .busy, .done, .itemTaken);
    fpet_flash_model fpet_flash_model_inst (.clk, .rst, .progEn, .eraseEn,
        .massEn, .progPulses, .erasePulses, .massPulses);
    // Stands in for the generator clock that software keeps in band;
    // phases are counted in periods, so one fixed rate serves
    initial forever #2.5 clk = ~clk;
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // One start; counts cycles to done, feeds items, may send a stray start
    task automatic launch(fpet_op_t o, int lastAt, int stray);
        int taken;
        taken = 0;
        op = o;
        start = 1'b1;
        @(posedge clk);
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n == 1) check("busy after start", busy, 32'h1);
            // A take seen now lands at the next rising edge, so the
            // item inputs change only once it has landed
            if (lastAt != 0 && taken == lastAt && itemTaken !== 1'b1)
                {itemValid, blockLast} = 2'h1;
            if (itemTaken === 1'b1) taken++;
            start = (n == stray);
        end while (done !== 1'b1 && n < 6000);
        check("done pulse", done, 32'h1);
        check("idle at done", busy, 32'h0);
        {itemValid, blockLast} = 2'h0;
        @(negedge clk);
        check("done one cycle", done, 32'h0);
    endtask
    task automatic test_word();
        launch(FPET_OP_WORD, 0, 0);
        check("word cycles", n, 32'h24);
        $display("test word done");
    endtask
    task automatic test_refuse();
        launch(FPET_OP_MASS_ERASE, 0, 0);
        check("mass cycles", n, 32'h14B2);
        check("mass flag", massEn, 32'h1);
        launch(FPET_OP_WORD, 0, 5);
        check("cycles with stray start", n, 32'h24);
        check("erases", erasePulses, 32'h1);
        $display("test refuse done");
    endtask
    task automatic test_blocks();
        itemValid = 1'b1;
        launch(FPET_OP_BLOCK, 2, 0);
        check("short block items", progPulses, 32'h5);
        check("short block cycles", n, 32'h52);
        itemValid = 1'b1;
        launch(FPET_OP_BLOCK, 0, 0);
        check("full block items", progPulses, 32'h45);
        check("full block cycles", n, 32'h590);
        // Limit in periods at the top of the band: 4 ms at 476 kHz
        check("block under time limit", n <= 32'h770, 32'h1);
        $display("test blocks done");
    endtask
    task automatic test_erase();
        launch(FPET_OP_SEG_ERASE, 0, 0);
        check("segment cycles", n, 32'h12D4);
        check("mass count", massPulses, 32'h1);
        check("erase count", erasePulses, 32'h2);
        check("segment not mass", massEn, 32'h0);
        $display("test erase done");
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard, about two and a half times the expected run
    initial begin
        #150us;
        fails++;
        summarize();
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        test_word();
        test_refuse();
        test_blocks();
        test_erase();
        summarize();
    end
endmodule // fpet_sequencer_tb_top
